// [bench/gain_ctrl_regs_chk.sv]
// Checker for the gain-control bank, bound by port name
`timescale 1ns/1ps
module gain_ctrl_regs_chk (
   input wire       CORE_CLK_IN, RST_IN, REG_WR_IN, COMPRESS_EN_IN,
   input wire       CH_ENHANCE_EN_IN, RANGE_OR_LEVEL_SELECT_IN,
   input wire [7:0] REG_ADDR_IN, REG_WDATA_IN, REG_RDATA_OUT,
   input wire [7:0] ENH_THRESHOLD_DB_OUT, ENH_GAIN_CEILING_DB_OUT,
   input wire [7:0] LEVEL_TARGET_DB_OUT, LEVEL_GAIN_CEILING_DB_OUT,
   input wire       ENHANCER_ACTIVE_OUT, LEVEL_CTRL_ACTIVE_OUT,
   input wire [6:0] GAIN_REQ_IN, GAIN_APPLIED_OUT
);
   reg        step_q;
   wire       we = REG_WR_IN && REG_ADDR_IN == 8'h6D;
   wire       wl = REG_WR_IN && REG_ADDR_IN == 8'h70;
   wire [7:0] hi = {4'h0, REG_WDATA_IN[7:4]};
   wire [7:0] lo = {4'h0, REG_WDATA_IN[3:0]};
   wire       on = !COMPRESS_EN_IN && CH_ENHANCE_EN_IN;
   wire       es = on && !RANGE_OR_LEVEL_SELECT_IN;
   wire       ls = on && RANGE_OR_LEVEL_SELECT_IN;
   default clocking @(posedge CORE_CLK_IN); endclocking
   default disable iff (RST_IN);
   // Mirrors the stepping half of the update mode
   always @(posedge CORE_CLK_IN)
      if (RST_IN) step_q <= 1'b0;
      else if (REG_WR_IN && REG_ADDR_IN == 8'h71) step_q <= REG_WDATA_IN[7];
   chk_thr_decode: assert property (we |-> ##2
      ENH_THRESHOLD_DB_OUT == 8'hF4 - 8'h06 * $past(hi, 2))
      else $error("thr");
   chk_enh_ceiling: assert property (we |-> ##2
      ENH_GAIN_CEILING_DB_OUT == 8'h02 + 8'h02 * $past(lo, 2))
      else $error("eg");
   chk_target_decode: assert property (wl |-> ##2
      LEVEL_TARGET_DB_OUT == 8'hFA - 8'h02 * $past(hi, 2))
      else $error("tgt");
   chk_lvl_ceiling: assert property (wl |-> ##2
      LEVEL_GAIN_CEILING_DB_OUT == 8'h03 + 8'h03 * $past(lo, 2))
      else $error("lg");
   chk_ro_zero: assert property ($past(REG_ADDR_IN) == 8'h71 |->
      REG_RDATA_OUT[4:0] == 5'h00) else $error("ro");
   chk_enh_active: assert property (!$past(RST_IN) |->
      ENHANCER_ACTIVE_OUT == $past(es)) else $error("ea");
   chk_lvl_active: assert property (!$past(RST_IN) |->
      LEVEL_CTRL_ACTIVE_OUT == $past(ls)) else $error("la");
   chk_gain_now: assert property (!step_q && GAIN_REQ_IN <= 7'h30 |=>
      GAIN_APPLIED_OUT == $past(GAIN_REQ_IN)) else $error("now");
   chk_step_size: assert property (step_q |=>
      GAIN_APPLIED_OUT - $past(GAIN_APPLIED_OUT) + 7'h01 <= 7'h02)
      else $error("step");
endmodule // gain_ctrl_regs_chk

// [bench/gain_ctrl_regs_tb.sv]
// Bench for gain_ctrl_regs; host model drives the register port
`timescale 1ns/1ps
module gain_ctrl_regs_tb;
   reg        clk = 1'b0, rst = 1'b1, cmp = 1'b0, ena = 1'b0, sel = 1'b0;
   reg        hiz = 1'b0;
   reg  [6:0] req = 7'h00;
   wire [7:0] addr, wdata, rdata, thr, egc, tgt, lgc;
   wire       wr, eact, lact, busy;
   wire [6:0] gain;
   reg  [7:0] d;
   integer    failures = 0, total_checks = 0, i, n, m;
   always #2.5 clk = ~clk;
   host_model host (.clk(clk), .rdata(rdata), .addr(addr), .wr(wr),
      .wdata(wdata));
   gain_ctrl_regs dut (.CORE_CLK_IN(clk), .RST_IN(rst), .REG_ADDR_IN(addr),
      .REG_WR_IN(wr), .REG_WDATA_IN(wdata), .REG_RDATA_OUT(rdata),
      .COMPRESS_EN_IN(cmp), .CH_ENHANCE_EN_IN(ena), .HIGH_IMPEDANCE_IN(hiz),
      .RANGE_OR_LEVEL_SELECT_IN(sel), .GAIN_REQ_IN(req),
      .ENH_THRESHOLD_DB_OUT(thr), .ENH_GAIN_CEILING_DB_OUT(egc),
      .LEVEL_TARGET_DB_OUT(tgt), .LEVEL_GAIN_CEILING_DB_OUT(lgc),
      .ENHANCER_ACTIVE_OUT(eact), .LEVEL_CTRL_ACTIVE_OUT(lact),
      .GAIN_APPLIED_OUT(gain), .GAIN_BUSY_OUT(busy));
   task chk(input [7:0] got, input [7:0] exp);
      total_checks = total_checks + 1;
      if (got !== exp) begin
         failures = failures + 1;
         $display("ERROR %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task rchk(input [7:0] a, input [7:0] exp);
      host.rd_reg(a, d);
      chk(d, exp);
   endtask
   task wait_gain(input [6:0] g);
      n = 0;
      while (gain !== g && n < 9000) begin
         @(posedge clk) #1 n = n + 1;
      end
   endtask
   task conclude;
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      #300000 failures = failures + 1;
      conclude;
   end
   initial begin
      repeat (5) @(posedge clk);
      #1 rst = 1'b0;
      rchk(8'h6D, 8'h7B);
      rchk(8'h70, 8'hE7);
      rchk(8'h71, 8'h00);
      rchk(8'h72, 8'h00);
      chk(thr, 8'hCA);
      chk(lgc, 8'h18);
      chk(egc, 8'h18);
      chk(tgt, 8'hDE);
      for (i = 0; i < 16; i = i + 1) begin
         n = (i > 9) ? 9 : i;
         m = (i > 12) ? 12 : i;
         host.wr_reg(8'h6D, {n[3:0], m[3:0]});
         host.wr_reg(8'h70, {i[3:0], (i > 13) ? 4'hD : i[3:0]});
         @(posedge clk) #1;
         chk(thr, 8'hF4 - 8'h06 * n[7:0]);
         chk(egc, 8'h02 + 8'h02 * m[7:0]);
         chk(tgt, 8'hFA - 8'h02 * i[7:0]);
         chk(lgc, 8'h03 + 8'h03 * ((i > 13) ? 8'h0D : i[7:0]));
      end
      host.wr_reg(8'h71, 8'h1F);
      rchk(8'h71, 8'h00);
      rst = 1'b1;
      @(posedge clk) #1 rst = 1'b0;
      rchk(8'h6D, 8'h7B);
      rchk(8'h70, 8'hE7);
      chk(thr, 8'hCA);
      for (i = 0; i < 8; i = i + 1) begin
         {cmp, ena, sel} = i[2:0];
         repeat (2) @(posedge clk);
         #1;
         chk({6'h00, eact, lact}, {6'h00, i == 2, i == 3});
      end
      for (i = 0; i < 4; i = i + 1) begin
         host.wr_reg(8'h71, {1'b0, i[1], 6'h00});
         {hiz, req} = {i[0], 7'h7F};
         repeat (2) @(posedge clk);
         #1;
         chk({1'b0, gain}, hiz ? 8'h30 : 8'h3C);
      end
      for (i = 2; i < 4; i = i + 1) begin
         req = 7'h00;
         host.wr_reg(8'h71, 8'h00);
         host.wr_reg(8'h71, {i[1:0], 6'h00});
         req = 7'h02;
         wait_gain(7'h01);
         chk({7'h00, busy}, 8'h01);
         wait_gain(7'h02);
         m = 4000 * (i - 1);
         chk({7'h00, n > m - 3 && n < m + 3}, 8'h01);
      end
      conclude;
   end
endmodule // gain_ctrl_regs_tb
bind gain_ctrl_regs gain_ctrl_regs_chk gain_chk (
   .CORE_CLK_IN(CORE_CLK_IN),
   .RST_IN(RST_IN),
   .REG_WR_IN(REG_WR_IN),
   .COMPRESS_EN_IN(COMPRESS_EN_IN),
   .CH_ENHANCE_EN_IN(CH_ENHANCE_EN_IN),
   .RANGE_OR_LEVEL_SELECT_IN(RANGE_OR_LEVEL_SELECT_IN),
   .REG_ADDR_IN(REG_ADDR_IN),
   .REG_WDATA_IN(REG_WDATA_IN),
   .REG_RDATA_OUT(REG_RDATA_OUT),
   .ENH_THRESHOLD_DB_OUT(ENH_THRESHOLD_DB_OUT),
   .ENH_GAIN_CEILING_DB_OUT(ENH_GAIN_CEILING_DB_OUT),
   .LEVEL_TARGET_DB_OUT(LEVEL_TARGET_DB_OUT),
   .LEVEL_GAIN_CEILING_DB_OUT(LEVEL_GAIN_CEILING_DB_OUT),
   .ENHANCER_ACTIVE_OUT(ENHANCER_ACTIVE_OUT),
   .LEVEL_CTRL_ACTIVE_OUT(LEVEL_CTRL_ACTIVE_OUT),
   .GAIN_REQ_IN(GAIN_REQ_IN),
   .GAIN_APPLIED_OUT(GAIN_APPLIED_OUT)
);

// [bench/host_model.sv]
// Host side of the decoded register port; caller gives the clock
`timescale 1ns/1ps
module host_model (
   input  wire       clk,
   input  wire [7:0] rdata,
   output reg  [7:0] addr = 8'h00,
   output reg        wr = 1'b0,
   output reg  [7:0] wdata = 8'h00
);
   // Only legal codes are passed in, bit 5 of 0x71 kept zero
   task wr_reg(input [7:0] a, input [7:0] d);
      @(posedge clk) #1 addr = a;
      wdata = d;
      wr = 1'b1;
      @(posedge clk) #1 wr = 1'b0;
      wdata = ~d;
   endtask
   task rd_reg(input [7:0] a, output [7:0] d);
      @(posedge clk) #1 addr = a;
      @(posedge clk) #1 d = rdata;
   endtask
endmodule // host_model

// [src/gain_ctrl_consts.vh]
// Register map and field constants for the gain-control configuration bank
// Assumes 8-bit register index from the control interface
`ifndef GAIN_CTRL_CONSTS_VH
`define GAIN_CTRL_CONSTS_VH
`define RANGE_ENH_CFG_ADDR   8'h6D
`define AUTO_LVL_CFG_ADDR    8'h70
`define GAIN_UPD_CFG_ADDR    8'h71
`define RANGE_ENH_CFG_RST    8'h7B
`define AUTO_LVL_CFG_RST     8'hE7
`define GAIN_UPD_CFG_RST     8'h00
`define HI_NIB_MSB           7
`define HI_NIB_LSB           4
`define LO_NIB_MSB           3
`define LO_NIB_LSB           0
`define UPD_MODE_MSB         7
`define UPD_MODE_LSB         6
`define UPD_RSVD_RW_BIT      5
`define UPD_RSVD_RO_MASK     8'hE0
`define CLK_PERIOD_PS        5000
`define STEP_20US_NS         20000
`define STEP_40US_NS         40000
// Step periods in core clock cycles, sized for the 14-bit tick counter
`define STEP_20US_CYC        14'h0FA0
`define STEP_40US_CYC        14'h1F40
`define HALF_DB_STEP         7'h01
`define GAIN_LIMIT_10K       7'h3C
`define GAIN_LIMIT_20K       7'h30
`endif

// [src/gain_ctrl_regs.v]
// Gain-control configuration registers and live channel gain stepper
// Assumes a decoded register access port from the control interface logic
//
// Contract
// - Threshold field bits 7-4; codes 0..9 map -12 dB down to -66 dB.
// - Enhancer gain field bits 3-0; codes 0..12 map 2 to 26 dB.
// - Target level field bits 7-4; codes 0..15 map -6 to -36 dB.
// - Level gain field bits 3-0; codes 0..13 map 3 to 42 dB.
// - Mode 0 applies a channel gain change at once.
// - Mode 1 applies the change at once, reduced artifacts, no stepping; the code handles it exactly as mode 0.
// - Mode 2 steps 0.5 dB every 20 us; limit 30 or 24 dB.
// - Mode 3 steps 0.5 dB every 40 us, same limits.
// - Bits 4-0 of update register read as zero.
// - Select bit picks enhancer at 0, level control at 1, when enabled.
`timescale 1ns/1ps
`include "gain_ctrl_consts.vh"
module gain_ctrl_regs (
   // Clock and reset
   input  wire       CORE_CLK_IN,
   input  wire       RST_IN,
   // Register access port
   input  wire [7:0] REG_ADDR_IN,
   input  wire       REG_WR_IN,
   input  wire [7:0] REG_WDATA_IN,
   output reg  [7:0] REG_RDATA_OUT,
   // Surrounding configuration
   input  wire       COMPRESS_EN_IN,
   input  wire       CH_ENHANCE_EN_IN,
   input  wire       RANGE_OR_LEVEL_SELECT_IN,
   input  wire       HIGH_IMPEDANCE_IN,
   input  wire [6:0] GAIN_REQ_IN,
   // Decoded settings, signed dB, and enhancer/level active flags
   output reg  [7:0] ENH_THRESHOLD_DB_OUT,
   output reg  [7:0] ENH_GAIN_CEILING_DB_OUT,
   output reg  [7:0] LEVEL_TARGET_DB_OUT,
   output reg  [7:0] LEVEL_GAIN_CEILING_DB_OUT,
   output reg        ENHANCER_ACTIVE_OUT,
   output reg        LEVEL_CTRL_ACTIVE_OUT,
   // Applied channel gain, 0.5 dB units
   output reg  [6:0] GAIN_APPLIED_OUT,
   output reg        GAIN_BUSY_OUT
);

   reg  [7:0]  range_enh_q;
   reg  [7:0]  auto_lvl_q;
   reg  [7:0]  gain_upd_q;
   reg  [6:0]  gain_q;
   reg  [6:0]  gain_d;
   reg  [13:0] tick_q;
   reg  [13:0] tick_d;
   reg  [7:0]  rdata_d;
   reg  [7:0]  thr_d;
   reg  [7:0]  egc_d;
   reg  [7:0]  tgt_d;
   reg  [7:0]  lgc_d;
   wire [3:0]  enh_thr     = range_enh_q[`HI_NIB_MSB:`HI_NIB_LSB];
   wire [3:0]  enh_ceil    = range_enh_q[`LO_NIB_MSB:`LO_NIB_LSB];
   wire [3:0]  lvl_tgt     = auto_lvl_q[`HI_NIB_MSB:`HI_NIB_LSB];
   wire [3:0]  lvl_ceil    = auto_lvl_q[`LO_NIB_MSB:`LO_NIB_LSB];
   wire [1:0]  upd_mode    = gain_upd_q[`UPD_MODE_MSB:`UPD_MODE_LSB];
   wire [6:0]  limit       = HIGH_IMPEDANCE_IN ? `GAIN_LIMIT_20K
                                               : `GAIN_LIMIT_10K;
   wire [6:0]  target      = (GAIN_REQ_IN > limit) ? limit : GAIN_REQ_IN;
   wire [13:0] period      = (upd_mode == 2'h3) ? `STEP_40US_CYC
                                                : `STEP_20US_CYC;

   // Register writes; reserved bit 5 stored as written
   always @(posedge CORE_CLK_IN) begin
      if (RST_IN) begin
         range_enh_q <= `RANGE_ENH_CFG_RST;
         auto_lvl_q  <= `AUTO_LVL_CFG_RST;
         gain_upd_q  <= `GAIN_UPD_CFG_RST;
      end else if (REG_WR_IN) begin
         if (REG_ADDR_IN == `RANGE_ENH_CFG_ADDR)
            range_enh_q <= REG_WDATA_IN;
         if (REG_ADDR_IN == `AUTO_LVL_CFG_ADDR)
            auto_lvl_q <= REG_WDATA_IN;
         if (REG_ADDR_IN == `GAIN_UPD_CFG_ADDR)
            gain_upd_q <= REG_WDATA_IN & `UPD_RSVD_RO_MASK;
      end
   end

   // Read mux; unmapped addresses read zero
   always @* begin
      case (REG_ADDR_IN)
         `RANGE_ENH_CFG_ADDR: rdata_d = range_enh_q;
         `AUTO_LVL_CFG_ADDR:  rdata_d = auto_lvl_q;
         `GAIN_UPD_CFG_ADDR:  rdata_d = gain_upd_q;
         default:             rdata_d = 8'h00;
      endcase
   end

   // Field decode to dB; reserved codes extend the same uniform steps
   always @* begin
      case (enh_thr)
         4'h0:    thr_d = 8'hF4;
         4'h1:    thr_d = 8'hEE;
         4'h2:    thr_d = 8'hE8;
         4'h3:    thr_d = 8'hE2;
         4'h4:    thr_d = 8'hDC;
         4'h5:    thr_d = 8'hD6;
         4'h6:    thr_d = 8'hD0;
         4'h7:    thr_d = 8'hCA;
         4'h8:    thr_d = 8'hC4;
         4'h9:    thr_d = 8'hBE;
         4'hA:    thr_d = 8'hB8;
         4'hB:    thr_d = 8'hB2;
         4'hC:    thr_d = 8'hAC;
         4'hD:    thr_d = 8'hA6;
         4'hE:    thr_d = 8'hA0;
         default: thr_d = 8'h9A;
      endcase
      case (enh_ceil)
         4'h0:    egc_d = 8'h02;
         4'h1:    egc_d = 8'h04;
         4'h2:    egc_d = 8'h06;
         4'h3:    egc_d = 8'h08;
         4'h4:    egc_d = 8'h0A;
         4'h5:    egc_d = 8'h0C;
         4'h6:    egc_d = 8'h0E;
         4'h7:    egc_d = 8'h10;
         4'h8:    egc_d = 8'h12;
         4'h9:    egc_d = 8'h14;
         4'hA:    egc_d = 8'h16;
         4'hB:    egc_d = 8'h18;
         4'hC:    egc_d = 8'h1A;
         4'hD:    egc_d = 8'h1C;
         4'hE:    egc_d = 8'h1E;
         default: egc_d = 8'h20;
      endcase
      case (lvl_tgt)
         4'h0:    tgt_d = 8'hFA;
         4'h1:    tgt_d = 8'hF8;
         4'h2:    tgt_d = 8'hF6;
         4'h3:    tgt_d = 8'hF4;
         4'h4:    tgt_d = 8'hF2;
         4'h5:    tgt_d = 8'hF0;
         4'h6:    tgt_d = 8'hEE;
         4'h7:    tgt_d = 8'hEC;
         4'h8:    tgt_d = 8'hEA;
         4'h9:    tgt_d = 8'hE8;
         4'hA:    tgt_d = 8'hE6;
         4'hB:    tgt_d = 8'hE4;
         4'hC:    tgt_d = 8'hE2;
         4'hD:    tgt_d = 8'hE0;
         4'hE:    tgt_d = 8'hDE;
         default: tgt_d = 8'hDC;
      endcase
      case (lvl_ceil)
         4'h0:    lgc_d = 8'h03;
         4'h1:    lgc_d = 8'h06;
         4'h2:    lgc_d = 8'h09;
         4'h3:    lgc_d = 8'h0C;
         4'h4:    lgc_d = 8'h0F;
         4'h5:    lgc_d = 8'h12;
         4'h6:    lgc_d = 8'h15;
         4'h7:    lgc_d = 8'h18;
         4'h8:    lgc_d = 8'h1B;
         4'h9:    lgc_d = 8'h1E;
         4'hA:    lgc_d = 8'h21;
         4'hB:    lgc_d = 8'h24;
         4'hC:    lgc_d = 8'h27;
         4'hD:    lgc_d = 8'h2A;
         4'hE:    lgc_d = 8'h2D;
         default: lgc_d = 8'h30;
      endcase
   end

   // Live gain update engine, step count in 0.5 dB
   always @* begin
      gain_d = gain_q;
      tick_d = tick_q;
      case (upd_mode)
         2'h0: begin
            gain_d = target;
            tick_d = 14'h0000;
         end
         2'h1: begin
            gain_d = target;
            tick_d = 14'h0000;
         end
         default: begin
            if (gain_q == target) begin
               tick_d = 14'h0000;
            end else if (tick_q >= period - 14'h0001) begin
               tick_d = 14'h0000;
               if (gain_q < target)
                  gain_d = gain_q + `HALF_DB_STEP;
               else
                  gain_d = gain_q - `HALF_DB_STEP;
            end else begin
               tick_d = tick_q + 14'h0001;
            end
         end
      endcase
   end

   always @(posedge CORE_CLK_IN) begin
      if (RST_IN) begin
         gain_q <= 7'h00;
         tick_q <= 14'h0000;
      end else begin
         gain_q <= gain_d;
         tick_q <= tick_d;
      end
   end

   // Registered outputs, dB decode with uniform steps
   always @(posedge CORE_CLK_IN) begin
      if (RST_IN) begin
         REG_RDATA_OUT             <= 8'h00;
         ENH_THRESHOLD_DB_OUT      <= 8'h00;
         ENH_GAIN_CEILING_DB_OUT   <= 8'h00;
         LEVEL_TARGET_DB_OUT       <= 8'h00;
         LEVEL_GAIN_CEILING_DB_OUT <= 8'h00;
         ENHANCER_ACTIVE_OUT       <= 1'b0;
         LEVEL_CTRL_ACTIVE_OUT     <= 1'b0;
         GAIN_APPLIED_OUT          <= 7'h00;
         GAIN_BUSY_OUT             <= 1'b0;
      end else begin
         REG_RDATA_OUT <= rdata_d;
         ENH_THRESHOLD_DB_OUT      <= thr_d;
         ENH_GAIN_CEILING_DB_OUT   <= egc_d;
         LEVEL_TARGET_DB_OUT       <= tgt_d;
         LEVEL_GAIN_CEILING_DB_OUT <= lgc_d;
         ENHANCER_ACTIVE_OUT   <= ~COMPRESS_EN_IN & CH_ENHANCE_EN_IN
                                  & ~RANGE_OR_LEVEL_SELECT_IN;
         LEVEL_CTRL_ACTIVE_OUT <= ~COMPRESS_EN_IN & CH_ENHANCE_EN_IN
                                  & RANGE_OR_LEVEL_SELECT_IN;
         GAIN_APPLIED_OUT <= gain_d;
         GAIN_BUSY_OUT    <= (gain_d != target);
      end
   end

endmodule // gain_ctrl_regs
